// ### boot_mode_serial_loader.sv
// boot-mode serial stream loader with reset input handling and apb status access
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module boot_mode_serial_loader (
    input  wire logic        i_clk,                 // reference clock, also the apb clock
    input  wire logic        i_rst_n,               // synchronous block reset
    input  wire logic        i_power_good,          // supply stable, async pin
    input  wire logic        i_serial_data,         // stream data pin
    input  wire logic        i_power_on_reset_n,    // cold reset pin
    input  wire logic        i_reset_n,             // general reset pin
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_boot_serial_clock,   // stream clock to the source
    output logic             o_load_done,           // all stream bits taken
    output logic [3:0]       o_wb_pattern,          // writeback pattern code
    output logic [3:0]       o_clk_mult,            // pipeline clock multiple
    output logic             o_big_endian,          // byte order
    output logic [1:0]       o_write_proto,         // write protocol code
    output logic             o_timer_route,         // timer interrupt onto line 5
    output logic [1:0]       o_drive_strength,      // driver strength code
    output logic             o_cold_reset,          // cold reset in progress
    output logic             o_warm_reset,          // warm reset in progress
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr
);

    // all state of the block in one record
    typedef struct packed {
        logic [1:0]                   pg_sync;      // power-good synchroniser
        logic [1:0]                   sd_sync;      // data synchroniser
        logic [1:0]                   por_sync;     // cold reset synchroniser
        logic [1:0]                   rst_sync;     // general reset synchroniser
        logic                         pg_prev;      // for the power-good rising edge
        logic [7:0]                   div_cnt;      // serial clock divider
        logic                         sclk;         // serial clock output
        boot_loader_pkg::load_phase_t phase;        // capture phase
        logic [8:0]                   bit_idx;      // next stream index
        logic [14:0]                  cap;          // captured low stream bits
        logic                         bad_fixed;    // a fixed-value bit arrived wrong
        logic [14:0]                  cfg;          // committed stream bits
        logic                         cfg_bad;      // committed fixed-bit error
        logic                         done;         // stream fully taken
        boot_loader_pkg::mode_fields_t fields;      // decoded fields
        logic                         rsvd_code;    // a reserved code was decoded
        logic                         route_mask;   // software timer route mask
        logic                         cold;         // cold reset seen
        logic                         warm;         // warm reset seen
        logic                         pready;
        logic [31:0]                  prdata;
        logic                         pslverr;
    } state_t;

    state_t s_q;
    state_t s_d;
    boot_loader_pkg::apb_req_t req;                 // bundled bus request
    boot_loader_pkg::mode_fields_t dec;             // decode of the committed bits
    logic                         rsvd_now;         // reserved code in committed bits
    logic                         pg_rise;          // synchronised power-good edge
    logic                         sample_now;       // serial clock rising edge

    assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr, pwdata: i_pwdata};

    // field decode from the committed bits
    always_comb begin
        dec.wb_pattern     = s_q.cfg[boot_loader_pkg::WB_LSB +: 4];
        dec.clk_mult       = 4'(s_q.cfg[boot_loader_pkg::MULT_LSB +: 3]) + boot_loader_pkg::MULT_BASE;
        dec.big_endian     = s_q.cfg[boot_loader_pkg::ENDIAN_BIT];
        dec.write_proto    = s_q.cfg[boot_loader_pkg::WPROT_LSB +: 2];
        // software can only add to the stream's routing disable, never override it
        dec.timer_route    = ~s_q.cfg[boot_loader_pkg::TIMER_BIT] & ~s_q.route_mask;
        dec.drive_strength = s_q.cfg[boot_loader_pkg::DRIVE_LSB +: 2];
        rsvd_now = (dec.wb_pattern > boot_loader_pkg::WB_MAX_CODE)
                 | (s_q.cfg[boot_loader_pkg::MULT_LSB +: 3] == boot_loader_pkg::MULT_RSVD)
                 | (dec.write_proto == boot_loader_pkg::WPROT_RSVD);
        // a reserved multiplier is not passed on; the lowest legal multiple is kept instead
        if (s_q.cfg[boot_loader_pkg::MULT_LSB +: 3] == boot_loader_pkg::MULT_RSVD) begin
            dec.clk_mult = boot_loader_pkg::MULT_RST;
        end
    end

    // next-state logic
    always_comb begin
        s_d = s_q;
        // synchronisers: first stage feeds only the second
        s_d.pg_sync  = {s_q.pg_sync[0], i_power_good};
        s_d.sd_sync  = {s_q.sd_sync[0], i_serial_data};
        s_d.por_sync = {s_q.por_sync[0], i_power_on_reset_n};
        s_d.rst_sync = {s_q.rst_sync[0], i_reset_n};        // async assertion is caught here
        s_d.pg_prev  = s_q.pg_sync[1];
        pg_rise      = s_q.pg_sync[1] & ~s_q.pg_prev;
        sample_now   = (s_q.div_cnt == (boot_loader_pkg::SAMPLE_PHASE - 8'h01));

        // divider runs freely, restarted by power-good so bit 0 lines up with it
        if (pg_rise) begin
            s_d.div_cnt = 8'h00;
            s_d.sclk    = 1'b0;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 8'h01;
            s_d.sclk    = s_d.div_cnt[7];
        end

        // stream capture
        case (s_q.phase)
            boot_loader_pkg::LOAD_IDLE: begin
                if (pg_rise) begin
                    s_d.phase     = boot_loader_pkg::LOAD_SHIFT;
                    s_d.bit_idx   = 9'h000;
                    s_d.cap       = boot_loader_pkg::CONFIG_RST;
                    s_d.bad_fixed = 1'b0;
                end
            end
            boot_loader_pkg::LOAD_SHIFT: begin
                if (sample_now) begin
                    // one sample per serial clock period; only the first 15 are landed, each at its own index
                    if (s_q.bit_idx < 9'(boot_loader_pkg::KEPT_BITS)) begin
                        s_d.cap[s_q.bit_idx[3:0]] = s_q.sd_sync[1];
                    end
                    // bit 0 zero, bit 12 one, bits 15 and up zero from the source
                    if (((s_q.bit_idx == 9'h000) && s_q.sd_sync[1])
                        || ((s_q.bit_idx == 9'(boot_loader_pkg::ONE_BIT)) && !s_q.sd_sync[1])
                        || ((s_q.bit_idx >= 9'(boot_loader_pkg::KEPT_BITS)) && s_q.sd_sync[1])) begin
                        s_d.bad_fixed = 1'b1;
                    end
                    s_d.bit_idx = s_q.bit_idx + 9'h001;
                    if (s_q.bit_idx == boot_loader_pkg::LAST_INDEX) begin
                        s_d.phase   = boot_loader_pkg::LOAD_DONE;
                        s_d.done    = 1'b1;
                        s_d.cfg     = s_d.cap;
                        s_d.cfg_bad = s_d.bad_fixed;
                    end
                end
                // a fresh power-good edge restarts the stream from bit 0
                if (pg_rise) begin
                    s_d.bit_idx   = 9'h000;
                    s_d.cap       = boot_loader_pkg::CONFIG_RST;
                    s_d.bad_fixed = 1'b0;
                    s_d.phase     = boot_loader_pkg::LOAD_SHIFT;
                end
            end
            boot_loader_pkg::LOAD_DONE: begin
                // clock keeps running, data pin is no longer looked at
                if (pg_rise) begin
                    s_d.phase     = boot_loader_pkg::LOAD_SHIFT;
                    s_d.bit_idx   = 9'h000;
                    s_d.cap       = boot_loader_pkg::CONFIG_RST;
                    s_d.bad_fixed = 1'b0;
                    s_d.done      = 1'b0;
                end
            end
            default: begin
                s_d.phase = boot_loader_pkg::LOAD_IDLE;
            end
        endcase

        // decoded fields registered; fields only move when committed bits or the route mask move
        s_d.fields    = dec;
        s_d.rsvd_code = rsvd_now;

        // reset pins: cold wins, general reset alone is a warm reset
        s_d.cold = ~s_q.por_sync[1];
        s_d.warm = s_q.por_sync[1] & ~s_q.rst_sync[1];

        // apb slave: answer one cycle into the access phase
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0000_0000;
        if (req.psel && req.penable && !s_q.pready) begin
            s_d.pready = 1'b1;
            case (req.paddr)
                boot_loader_pkg::OFS_CONFIG: begin
                    s_d.prdata = {17'h0_0000, s_q.cfg};
                end
                boot_loader_pkg::OFS_STATUS: begin
                    s_d.prdata = {17'h0_0000, s_q.bit_idx, s_q.cfg_bad, s_q.rsvd_code,
                                  s_q.warm, s_q.cold, s_q.pg_sync[1], s_q.done};
                end
                boot_loader_pkg::OFS_CONTROL: begin
                    s_d.prdata = {31'h0000_0000, s_q.route_mask};
                    if (req.pwrite) begin
                        s_d.route_mask = req.pwdata[0];
                    end
                end
                boot_loader_pkg::OFS_DECODE: begin
                    s_d.prdata = {18'h0_0000, s_q.fields};
                end
                default: begin
                    // unmapped: error answer, nothing written
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
    end

    // register the state record
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q            <= '0;
            s_q.phase      <= boot_loader_pkg::LOAD_IDLE;
            s_q.cfg        <= boot_loader_pkg::CONFIG_RST;
            s_q.route_mask <= boot_loader_pkg::CONTROL_RST;
            s_q.fields     <= '{wb_pattern: 4'h0, clk_mult: boot_loader_pkg::MULT_RST, big_endian: 1'b0,
                                write_proto: 2'h0, timer_route: 1'b1, drive_strength: 2'h0};
            s_q.por_sync   <= 2'b11;
            s_q.rst_sync   <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign o_boot_serial_clock = s_q.sclk;
    assign o_load_done         = s_q.done;
    assign o_wb_pattern        = s_q.fields.wb_pattern;
    assign o_clk_mult          = s_q.fields.clk_mult;
    assign o_big_endian        = s_q.fields.big_endian;
    assign o_write_proto       = s_q.fields.write_proto;
    assign o_timer_route       = s_q.fields.timer_route;
    assign o_drive_strength    = s_q.fields.drive_strength;
    assign o_cold_reset        = s_q.cold;
    assign o_warm_reset        = s_q.warm;
    assign o_pready            = s_q.pready;
    assign o_prdata            = s_q.prdata;
    assign o_pslverr           = s_q.pslverr;

endmodule

// ### boot_loader_pkg.sv
// shared constants and carrier types for the boot-mode serial loader
package boot_loader_pkg;

    // serial clock divider and stream geometry
    localparam int unsigned SCLK_DIV      = 256;            // reference clock cycles per serial clock period
    localparam int unsigned STREAM_BITS   = 256;            // bits read after power-good
    localparam logic [7:0]  SAMPLE_PHASE  = 8'h80;          // divider count at the serial clock rising edge
    localparam logic [8:0]  LAST_INDEX    = 9'h0FF;         // index of the final stream bit
    localparam int unsigned KEPT_BITS     = 15;             // low stream bits that carry mode fields

    // stream field positions
    localparam int unsigned WB_LSB        = 1;              // writeback pattern, bits 4:1
    localparam int unsigned MULT_LSB      = 5;              // clock multiplier code, bits 7:5
    localparam int unsigned ENDIAN_BIT    = 8;              // byte order select
    localparam int unsigned WPROT_LSB     = 9;              // write protocol, bits 10:9
    localparam int unsigned TIMER_BIT     = 11;             // timer interrupt routing disable
    localparam int unsigned ONE_BIT       = 12;             // must be supplied as one
    localparam int unsigned DRIVE_LSB     = 13;             // drive strength, bits 14:13

    // decode limits
    localparam logic [3:0]  WB_MAX_CODE   = 4'h8;           // codes above are reserved
    localparam logic [2:0]  MULT_RSVD     = 3'h7;           // reserved multiplier code
    localparam logic [3:0]  MULT_BASE     = 4'h2;           // code 0 selects a multiple of 2
    localparam logic [1:0]  WPROT_RSVD    = 2'h1;           // reserved write protocol

    // apb register offsets
    localparam logic [7:0]  OFS_CONFIG    = 8'h00;          // captured stream bits 14:0
    localparam logic [7:0]  OFS_STATUS    = 8'h04;          // loader and reset state
    localparam logic [7:0]  OFS_CONTROL   = 8'h08;          // software control
    localparam logic [7:0]  OFS_DECODE    = 8'h0C;          // decoded fields

    // reset values
    localparam logic [14:0] CONFIG_RST    = 15'h0000;       // fields before the first stream
    localparam logic [0:0]  CONTROL_RST   = 1'h0;           // timer route mask off
    localparam logic [3:0]  MULT_RST      = 4'h2;           // lowest legal multiple

    // capture phase
    typedef enum logic [1:0] {
        LOAD_IDLE,
        LOAD_SHIFT,
        LOAD_DONE
    } load_phase_t;

    // decoded mode fields as seen by the rest of the core
    typedef struct packed {
        logic [3:0] wb_pattern;     // writeback word / idle pattern code
        logic [3:0] clk_mult;       // pipeline clock multiple, 2..8
        logic       big_endian;     // one selects big endian
        logic [1:0] write_proto;    // write protocol code
        logic       timer_route;    // timer interrupt merged onto line 5
        logic [1:0] drive_strength; // output driver strength code
    } mode_fields_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// ### boot_loader_chk.sv
// concurrent checks on the boot-mode loader ports
`timescale 1ns/1ps
module boot_loader_chk (
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_power_good,
    input wire logic       i_power_on_reset_n,
    input wire logic       i_reset_n,
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic       o_boot_serial_clock,
    input wire logic       o_load_done,
    input wire logic [3:0] o_wb_pattern,
    input wire logic [3:0] o_clk_mult,
    input wire logic       o_big_endian,
    input wire logic [1:0] o_write_proto,
    input wire logic       o_timer_route,
    input wire logic [1:0] o_drive_strength,
    input wire logic       o_cold_reset,
    input wire logic       o_warm_reset,
    input wire logic       o_pready,
    input wire logic       o_pslverr
);
    logic [8:0]  rises_q; // serial clock rises since power-good rose
    logic        pg_q;    // power-good one cycle ago
    logic        sclk_q;  // serial clock one cycle ago
    logic [12:0] fields;  // decoded fields side by side
    logic        take;    // apb access taken at this edge
    assign fields = {o_wb_pattern, o_clk_mult, o_big_endian, o_write_proto, o_drive_strength};
    assign take = i_psel && i_penable && !o_pready;
    // count rises so the done moment is tied to the bit count; saturates, never wraps
    always_ff @(posedge i_clk) begin
        pg_q <= i_power_good;
        sclk_q <= o_boot_serial_clock;
        if (!i_rst_n || (i_power_good && !pg_q)) begin
            rises_q <= 9'h000;
        end else if (o_boot_serial_clock && !sclk_q && rises_q != 9'h1ff) begin
            rises_q <= rises_q + 9'h001;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_sclk_high_phase: assert property ($rose(o_boot_serial_clock) |-> ##128 $fell(o_boot_serial_clock))
        else $error("serial clock high phase wrong");
    // the rise that takes bit 255 lands on the same edge as done, so it is not counted yet
    a_done_bit_count: assert property ($rose(o_load_done) |-> rises_q == 9'h0ff)
        else $error("load done after wrong bit count");
    a_restart_clears: assert property ($rose(i_power_good) |-> ##[1:6] !o_load_done)
        else $error("power-good did not restart the load");
    a_fields_hold: assert property (o_load_done && $past(o_load_done, 3) |-> $stable(fields))
        else $error("fields moved after load");
    a_mult_range: assert property (o_clk_mult inside {[4'h2:4'h8]})
        else $error("clock multiple out of range");
    a_cold_follow: assert property ((!i_power_on_reset_n) [*4] |-> o_cold_reset && !o_warm_reset)
        else $error("cold reset not seen");
    a_warm_follow: assert property ((!i_reset_n && i_power_on_reset_n) [*4] |-> o_warm_reset && !o_cold_reset)
        else $error("warm reset not seen");
    a_warm_ends: assert property ((i_reset_n) [*4] |-> !o_warm_reset)
        else $error("warm reset without general reset");
    a_apb_answer: assert property (take |=> o_pready ##1 !o_pready)
        else $error("apb answer not a one-cycle pulse");
    a_unmapped_err: assert property (take && i_paddr > boot_loader_pkg::OFS_DECODE |=> o_pslverr)
        else $error("unmapped access without error");
    c_load_done: cover property ($rose(o_load_done));
    c_warm: cover property ($rose(o_warm_reset));
    c_slverr: cover property (o_pslverr);
endmodule

// ### boot_stream_source.sv
// behavioural serial source feeding the mode stream to the loader
`timescale 1ns/1ps
module boot_stream_source (
    input  wire logic         i_clk,        // reference clock
    input  wire logic         i_power_good, // stream restarts at its rise
    input  wire logic         i_sclk,       // serial clock from the loader
    input  wire logic [255:0] i_stream,     // bits to send, bit 0 first
    output logic              o_data        // serial data pin
);
    logic [8:0] rise_q;       // rises seen since power-good
    logic [8:0] cur_q;        // index of the bit on the pin
    logic       sclk_q;       // serial clock one cycle ago
    logic       alt_q = 1'h0; // filler that moves once the stream is spent
    // bit 0 waits while power-good is low, so it is there at the rise
    always_ff @(posedge i_clk) begin
        sclk_q <= i_sclk;
        alt_q <= ~alt_q;
        if (!i_power_good) begin
            rise_q <= 9'h000;
            cur_q <= 9'h000;
        end else begin
            if (i_sclk && !sclk_q) begin
                rise_q <= rise_q + 9'h001;
            end
            // change after a fall, far from the sampling rise
            if (!i_sclk && sclk_q) begin
                cur_q <= rise_q;
            end
        end
    end
    // past bit 255 the pin keeps changing, so a late sample would show
    assign o_data = cur_q[8] ? alt_q : i_stream[cur_q[7:0]];
endmodule

// ### boot_mode_serial_loader_bench.sv
// self-checking bench for the boot-mode serial loader
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module boot_mode_serial_loader_bench;
    logic         clk, rst_n, pg, por_n, grst_n, sdata; // clock, resets, pins
    logic         psel, penable, pwrite, err;           // apb request
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rdata;
    logic         sclk, done, endian, troute, cold, warm, pready, slverr;
    logic [3:0]   wb, mult;
    logic [1:0]   proto, drive;
    logic [255:0] stream;                               // bits the source sends
    int           errors, compares, cycles;
    boot_mode_serial_loader uut (.i_clk(clk), .i_rst_n(rst_n), .i_power_good(pg), .i_serial_data(sdata),
        .i_power_on_reset_n(por_n), .i_reset_n(grst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_boot_serial_clock(sclk),
        .o_load_done(done), .o_wb_pattern(wb), .o_clk_mult(mult), .o_big_endian(endian),
        .o_write_proto(proto), .o_timer_route(troute), .o_drive_strength(drive), .o_cold_reset(cold),
        .o_warm_reset(warm), .o_pready(pready), .o_prdata(prdata), .o_pslverr(slverr));
    boot_stream_source src (.i_clk(clk), .i_power_good(pg), .i_sclk(sclk), .i_stream(stream), .o_data(sdata));
    // stream image; bit 12 set and the top bits clear as the source must
    function automatic logic [255:0] mk(logic [3:0] w, logic [2:0] m, logic e, logic [1:0] p, logic t, logic [1:0] d);
        mk = {241'h0, d, 1'h1, t, p, e, m, w, 1'h0};
    endfunction
    // one apb transfer; an idle edge first so strobes never change twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rdata = prdata;
        err = slverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic results();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // one stream is about 66k cycles, so the ceiling leaves some slack
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            results();
        end
    end
    initial begin
        {rst_n, pg, psel, penable, pwrite, paddr, pwdata} = '0;
        por_n = 1'h1;
        grst_n = 1'h1;
        stream = mk(4'hf, 3'h7, 1'h0, 2'h1, 1'h0, 2'h2); // reserved codes, aborted below
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        `CHK({wb, mult, endian, proto, troute, drive, done}, 15'h0108)
        pg <= 1'h1;
        apb(1'h1, boot_loader_pkg::OFS_CONTROL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK(troute, 1'h0)
        apb(1'h0, boot_loader_pkg::OFS_CONTROL, 32'h0000_0000);
        `CHK(rdata, 32'h0000_0001)
        apb(1'h1, boot_loader_pkg::OFS_CONTROL, 32'h0000_0000);
        apb(1'h1, boot_loader_pkg::OFS_CONFIG, 32'h0000_7fff);
        apb(1'h0, boot_loader_pkg::OFS_CONFIG, 32'h0000_0000);
        `CHK(rdata, 32'h0000_0000)
        apb(1'h0, 8'h10, 32'h0000_0000);
        `CHK(err, 1'h1)
        // restart mid-stream while the serial clock is low
        repeat (20) @(negedge sclk);
        @(posedge clk);
        pg <= 1'h0;
        stream <= mk(4'h8, 3'h6, 1'h1, 2'h3, 1'h1, 2'h1);
        repeat (8) @(posedge clk);
        `CHK(done, 1'h0)
        pg <= 1'h1;
        while (done !== 1'h1) @(posedge clk);
        repeat (4) @(posedge clk);
        `CHK(wb, 4'h8)
        `CHK(mult, 4'h8)
        `CHK(endian, 1'h1)
        `CHK(proto, 2'h3)
        `CHK(troute, 1'h0)
        `CHK(drive, 2'h1)
        apb(1'h0, boot_loader_pkg::OFS_CONFIG, 32'h0000_0000);
        `CHK(rdata, {17'h0, stream[14:0]})
        apb(1'h0, boot_loader_pkg::OFS_STATUS, 32'h0000_0000);
        `CHK(rdata[14:0], 15'h4003)
        repeat (600) @(posedge clk);
        apb(1'h0, boot_loader_pkg::OFS_DECODE, 32'h0000_0000);
        `CHK(rdata, 32'h0000_2239)
        // the source keeps toggling its pin; index and fixed-bit error must not move
        apb(1'h0, boot_loader_pkg::OFS_STATUS, 32'h0000_0000);
        `CHK(rdata[14:0], 15'h4003)
        grst_n <= 1'h0;
        repeat (5) @(posedge clk);
        `CHK({cold, warm}, 2'h1)
        por_n <= 1'h0;
        repeat (5) @(posedge clk);
        `CHK({cold, warm}, 2'h2)
        por_n <= 1'h1;
        grst_n <= 1'h1;
        repeat (5) @(posedge clk);
        `CHK({cold, warm}, 2'h0)
        apb(1'h0, boot_loader_pkg::OFS_DECODE, 32'h0000_0000);
        `CHK(rdata, 32'h0000_2239)
        results();
    end
endmodule
bind boot_mode_serial_loader boot_loader_chk chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_good(i_power_good),
    .i_power_on_reset_n(i_power_on_reset_n), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_boot_serial_clock(o_boot_serial_clock), .o_load_done(o_load_done),
    .o_wb_pattern(o_wb_pattern), .o_clk_mult(o_clk_mult), .o_big_endian(o_big_endian),
    .o_write_proto(o_write_proto), .o_timer_route(o_timer_route), .o_drive_strength(o_drive_strength),
    .o_cold_reset(o_cold_reset), .o_warm_reset(o_warm_reset), .o_pready(o_pready), .o_pslverr(o_pslverr));
